// ### rtl/ocrf_pkg.sv
// Package for the offcore response event filter: map, fields, carriers
package ocrf_pkg;

  // Register index map of the plain software port
  localparam logic [11:0] ADDR_CFG_A = 12'h1A6; // Filter configuration, sub-code one
  localparam logic [11:0] ADDR_CFG_B = 12'h1A7; // Filter configuration, sub-code two
  localparam logic [11:0] ADDR_CNT_0 = 12'h0C1; // Programmable event counter 0
  localparam logic [11:0] ADDR_CNT_1 = 12'h0C2; // Programmable event counter 1

  // Event selection codes
  localparam logic [7:0] EVT_OFFCORE = 8'hB7; // Offcore response event number
  localparam logic [7:0] SUB_CFG_A = 8'h01; // Sub-code that picks config A
  localparam logic [7:0] SUB_CFG_B = 8'h02; // Sub-code that picks config B

  // Field positions inside a filter register
  localparam int REQ_LSB = 0; // Request type field low bit
  localparam int REQ_MSB = 15; // Request type field high bit
  localparam int RSP_LSB = 16; // Response field low bit
  localparam int RSP_MSB = 37; // Response field high bit
  localparam int BIT_ANY = 16; // Catch-all response bit
  localparam int BIT_SECOND_LEVEL_HIT = 18; // Supplier: second-level hit, M/E/S
  localparam int SUP_MSB = 30; // Supplier field high bit
  localparam int SNP_LSB = 31; // Snoop field low bit
  localparam int BIT_LAT_EN = 38; // Mean delay enable, config A only
  localparam int CFG_W = 39; // Stored width of a filter register

  // Request type bit positions as carried on the request path
  localparam int RQ_DEMAND_DATA_READ = 0; // Demand and L1 prefetch data reads
  localparam int RQ_DEMAND_OWNERSHIP_READ = 1; // Demand and L1 prefetch ownership reads
  localparam int RQ_DEMAND_CODE_READ = 2; // Demand and L1 prefetch code reads
  localparam int RQ_WRITEBACK_REQUEST = 3; // Modified-to-exclusive writeback
  localparam int RQ_PREFETCH_DATA_READ = 4; // L2 prefetcher data read
  localparam int RQ_PREFETCH_OWNERSHIP_READ = 5; // L2 prefetcher ownership read
  localparam int RQ_PREFETCH_CODE_READ = 6; // L2 prefetcher code read
  localparam int RQ_PARTIAL_READ = 7; // Demand partial-line read
  localparam int RQ_PARTIAL_WRITE = 8; // Demand partial-line ownership write
  localparam int RQ_UNCACHED_CODE_FETCH = 9; // Uncached instruction fetch
  localparam int RQ_LOCKED_ACCESS_REQUEST = 10; // Bus and split locks
  localparam int RQ_STREAMING_STORE = 11; // Streaming store
  localparam int RQ_SOFTWARE_PREFETCH = 12; // Software prefetch
  localparam int RQ_L1_HW_PREFETCH_READ = 13; // L1 hardware prefetch data read
  localparam int RQ_PARTIAL_STREAMING_STORE = 14; // Partial streaming store
  localparam int RQ_OTHER = 15; // Anything else on the core_uncore_link

  // Writable bits; reserved 17, 19..30, 32, 35 stay zero
  localparam logic [CFG_W-1:0] MASK_CFG_B = 39'h36_8005_FFFF;
  localparam logic [CFG_W-1:0] MASK_CFG_A = 39'h76_8005_FFFF;
  localparam logic [CFG_W-1:0] RST_CFG = 39'h00_0000_0000; // Filters off at reset

  // Request issued toward the uncore
  typedef struct packed {
    logic valid; // One-cycle issue strobe
    logic [15:0] req_type; // One-hot request class
  } ocrf_req_s;

  // Response returned for an earlier request
  typedef struct packed {
    logic valid; // One-cycle response strobe
    logic [15:0] req_type; // Class of the request answered
    logic [21:0] info; // Supplier and snoop info, positions 37..16
  } ocrf_rsp_s;

  // Event selection seen by the filter
  typedef struct packed {
    logic enable; // Counter 0 is programmed and running
    logic [7:0] code; // Event number
    logic [7:0] sub_code; // Event sub-code
  } ocrf_evt_s;

endpackage

// ### rtl/ocrf_filter.sv
// Offcore response event filter with its two filter registers and counters
//
// Overview of operation
// - Event B7/sub 01 filters via config A
// - Event B7/sub 02 filters via config B
// - Bits 15:0 select eligible request types
// - Bits 30:16 select response suppliers
// - Bits 37:31 select snoop responses
// - No request bit or bad pattern counts zero
// - Valid: catch-all, or supplier and snoop
// - Catch-all bit 16 ignores supplier, snoop bits
// - Any selected combination of bits matches
// - Bits 0-2: demand data, ownership, code reads
// - Bit 3 writeback; bits 4-6 L2 prefetches
// - Bits 7-9: partial read, write, uncached fetch
// - Bits 10-15: locks, stores, prefetches, other
// - Bit 18 second-level hit; others reserved
// - Snoop bits 31,33,34,36; 32,35 reserved
// - Bit 37 matches non-memory targets
// - Only config A holds mean delay bit
// - Latency mode: counter 0 sums outstanding
// - Latency mode: counter 1 counts new requests
//
// Notes for users
// Registers are reached by plain index, not by byte address.
// Reserved filter bits are dropped on write and read as zero.
// Counter 0 and counter 1 sit at their own indices, read/write.
// A counter write wins over counting in that same cycle.
// Normal mode counts only into counter 0, one per response.
// Latency mode needs the event enabled with sub-code one.
// Response bits are not looked at in latency mode at all.
// Outstanding requests saturate, so a flood reads low, not wrong.
// The tracker clears whenever latency mode drops out.
// A response with no tracked request left is ignored.
// The mode flag is a level, not a registered output.
// Read data stands one cycle after the strobe, zero otherwise.
// The counters wrap silently at their full width.
`timescale 1ns/100ps
`default_nettype none

module ocrf_filter #(
  parameter int CNT_W = 48, // Event counter width
  parameter int OUT_W = 6 // Outstanding request tracker width
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Software register port
  input wire logic [11:0] i_addr,
  input wire logic [63:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [63:0] o_rdata,
  // Event selection and core offcore path
  input wire ocrf_pkg::ocrf_evt_s i_evt,
  input wire ocrf_pkg::ocrf_req_s i_req,
  input wire ocrf_pkg::ocrf_rsp_s i_rsp,
  // Counter values and latency mode flag
  output logic [CNT_W-1:0] o_cnt0,
  output logic [CNT_W-1:0] o_cnt1,
  output logic o_lat_mode
);

  // Refuse widths that the read path or adders cannot serve
  initial begin
    if (CNT_W < 8 || CNT_W > 63 || OUT_W < 1 || OUT_W >= CNT_W) begin
      $error("ocrf_filter: unsupported CNT_W or OUT_W");
    end
  end

  // Whole module state
  typedef struct packed {
    logic [ocrf_pkg::CFG_W-1:0] cfg_a; // Filter register A
    logic [ocrf_pkg::CFG_W-1:0] cfg_b; // Filter register B
    logic [CNT_W-1:0] cnt0; // Counter 0
    logic [CNT_W-1:0] cnt1; // Counter 1
    logic [OUT_W-1:0] outst; // Outstanding selected requests
    logic [63:0] rdata; // Read answer
  } ocrf_state_s;

  ocrf_state_s state; // Registered state
  ocrf_state_s next_state; // Next state

  // Decoded selection
  logic is_evt; // Offcore event programmed and enabled
  logic sel_a; // Sub-code one chosen
  logic sel_b; // Sub-code two chosen
  logic [ocrf_pkg::CFG_W-1:0] cfg; // Filter in use
  logic lat_mode; // Mean delay measurement active
  logic cfg_valid; // Filter has request and valid response pattern
  logic req_hit; // Response belongs to a selected request type
  logic sup_any; // A selected supplier reported
  logic snp_any; // A selected snoop outcome reported
  logic rsp_hit; // Response matches response field
  logic norm_inc; // Normal mode count pulse
  logic lat_issue; // New selected request issued
  logic lat_done; // Selected request completed
  logic wr_cnt0; // Software writes counter 0
  logic wr_cnt1; // Software writes counter 1
  logic [CNT_W-1:0] outst_ext; // Outstanding count widened

  // Event and filter decode
  // Selection comes from same-clock logic, so no synchroniser here.
  // An unknown sub-code falls back to an all-zero filter, which
  // is invalid and therefore can never count.
  always_comb begin
    is_evt = i_evt.enable && (i_evt.code == ocrf_pkg::EVT_OFFCORE);
    sel_a = is_evt && (i_evt.sub_code == ocrf_pkg::SUB_CFG_A);
    sel_b = is_evt && (i_evt.sub_code == ocrf_pkg::SUB_CFG_B);
    // Pick the register; neither chosen means an all-zero filter
    if (sel_a) begin
      cfg = state.cfg_a;
    end else if (sel_b) begin
      cfg = state.cfg_b;
    end else begin
      cfg = ocrf_pkg::RST_CFG;
    end
    // Latency mode lives only in config A
    lat_mode = sel_a && state.cfg_a[ocrf_pkg::BIT_LAT_EN];
  end

  // Matching of request and response against the filter
  // Each response carries its request class and its response bits.
  // Matching is pure logic on the response strobe cycle, so a
  // back-to-back stream of responses counts once per cycle.
  // The validity term guards filters that software left half set.
  always_comb begin
    // Request bit n stands for class n, any of several may be set
    req_hit = |(i_rsp.req_type & cfg[ocrf_pkg::REQ_MSB:ocrf_pkg::REQ_LSB]);
    // Supplier bits 30:17; only 18 is writable, reserved ones read zero
    sup_any = |(i_rsp.info[ocrf_pkg::SUP_MSB-ocrf_pkg::RSP_LSB:1]
                & cfg[ocrf_pkg::SUP_MSB:ocrf_pkg::RSP_LSB+1]);
    // Snoop bits 37:31, including the non-memory target bit
    snp_any = |(i_rsp.info[ocrf_pkg::RSP_MSB-ocrf_pkg::RSP_LSB:ocrf_pkg::SNP_LSB-ocrf_pkg::RSP_LSB]
                & cfg[ocrf_pkg::RSP_MSB:ocrf_pkg::SNP_LSB]);
    // Catch-all overrides supplier and snoop selection
    if (cfg[ocrf_pkg::BIT_ANY]) begin
      rsp_hit = 1'b1;
    end else begin
      rsp_hit = sup_any && snp_any;
    end
    // A filter with no request or no valid response pattern counts nothing
    cfg_valid = (|cfg[ocrf_pkg::REQ_MSB:ocrf_pkg::REQ_LSB])
                && (cfg[ocrf_pkg::BIT_ANY]
                    || ((|cfg[ocrf_pkg::SUP_MSB:ocrf_pkg::RSP_LSB+1])
                        && (|cfg[ocrf_pkg::RSP_MSB:ocrf_pkg::SNP_LSB])));
    norm_inc = !lat_mode && cfg_valid && i_rsp.valid && req_hit && rsp_hit;
  end

  // Latency mode request tracking
  // Issue and completion in one cycle leave the tracker as it was.
  // Completions below zero are dropped; they belong to requests
  // issued before the mode was switched on.
  always_comb begin
    // Response bits are ignored here; software keeps them cleared
    lat_issue = lat_mode && i_req.valid
                && (|(i_req.req_type & state.cfg_a[ocrf_pkg::REQ_MSB:ocrf_pkg::REQ_LSB]));
    lat_done = lat_mode && i_rsp.valid && (state.outst != '0)
               && (|(i_rsp.req_type & state.cfg_a[ocrf_pkg::REQ_MSB:ocrf_pkg::REQ_LSB]));
    outst_ext = {{(CNT_W-OUT_W){1'b0}}, state.outst};
    wr_cnt0 = i_wr && (i_addr == ocrf_pkg::ADDR_CNT_0);
    wr_cnt1 = i_wr && (i_addr == ocrf_pkg::ADDR_CNT_1);
  end

  // Next state: register writes, counting, read answer
  // A filter write takes effect for responses from the next cycle.
  // Counting and register writes share this one process so that
  // the priority between them is plain to see.
  always_comb begin
    next_state = state;
    // Filter register writes; reserved bits are masked off
    if (i_wr && i_addr == ocrf_pkg::ADDR_CFG_A) begin
      next_state.cfg_a = i_wdata[ocrf_pkg::CFG_W-1:0] & ocrf_pkg::MASK_CFG_A;
    end
    if (i_wr && i_addr == ocrf_pkg::ADDR_CFG_B) begin
      // No latency bit in config B
      next_state.cfg_b = i_wdata[ocrf_pkg::CFG_W-1:0] & ocrf_pkg::MASK_CFG_B;
    end
    // Outstanding tracker, cleared whenever latency mode is off
    if (!lat_mode) begin
      next_state.outst = '0;
    end else if (lat_issue && !lat_done) begin
      // Saturate rather than wrap; a wrap would corrupt the average badly
      if (state.outst != '1) begin
        next_state.outst = state.outst + OUT_W'(1);
      end
    end else if (lat_done && !lat_issue) begin
      next_state.outst = state.outst - OUT_W'(1);
    end
    // Counter 0: software write wins over counting in the same cycle
    if (wr_cnt0) begin
      next_state.cnt0 = i_wdata[CNT_W-1:0];
    end else if (lat_mode) begin
      next_state.cnt0 = state.cnt0 + outst_ext;
    end else if (norm_inc) begin
      next_state.cnt0 = state.cnt0 + CNT_W'(1);
    end
    // Counter 1 counts selected request issues in latency mode
    if (wr_cnt1) begin
      next_state.cnt1 = i_wdata[CNT_W-1:0];
    end else if (lat_issue) begin
      next_state.cnt1 = state.cnt1 + CNT_W'(1);
    end
    // Read answer, standing only in the cycle after the strobe
    next_state.rdata = 64'h0000_0000_0000_0000;
    if (i_rd) begin
      case (i_addr)
        ocrf_pkg::ADDR_CFG_A: next_state.rdata = {{(64-ocrf_pkg::CFG_W){1'b0}}, state.cfg_a};
        ocrf_pkg::ADDR_CFG_B: next_state.rdata = {{(64-ocrf_pkg::CFG_W){1'b0}}, state.cfg_b};
        ocrf_pkg::ADDR_CNT_0: next_state.rdata = {{(64-CNT_W){1'b0}}, state.cnt0};
        ocrf_pkg::ADDR_CNT_1: next_state.rdata = {{(64-CNT_W){1'b0}}, state.cnt1};
        // Unmapped addresses answer zero
        default: next_state.rdata = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  // State register, synchronous reset
  // Reset loads constants only; filters come up off.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      next_state_reset: begin
        state.cfg_a <= ocrf_pkg::RST_CFG;
        state.cfg_b <= ocrf_pkg::RST_CFG;
        state.cnt0 <= '0;
        state.cnt1 <= '0;
        state.outst <= '0;
        state.rdata <= 64'h0000_0000_0000_0000;
      end
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops, except the mode flag
  assign o_rdata = state.rdata;
  assign o_cnt0 = state.cnt0;
  assign o_cnt1 = state.cnt1;
  assign o_lat_mode = lat_mode;

  // Checks, all in the one clock domain
  // They are held off during reset; state is unknown before it.
  // All but a_any_overrides and a_reserved_clear look one cycle ahead, where the state has moved.
  default clocking ocrf_cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_sub_one_count: assert property (
    (sel_a && !state.cfg_a[ocrf_pkg::BIT_LAT_EN] && i_rsp.valid && !wr_cnt0
     && |(i_rsp.req_type & state.cfg_a[15:0]) && state.cfg_a[ocrf_pkg::BIT_ANY])
    |=> (state.cnt0 == $past(state.cnt0) + CNT_W'(1)))
    else $error("config A match did not bump counter 0");

  a_sub_two_count: assert property (
    (sel_b && i_rsp.valid && !wr_cnt0 && req_hit && rsp_hit && cfg_valid)
    |=> (state.cnt0 == $past(state.cnt0) + CNT_W'(1)))
    else $error("config B match did not bump counter 0");

  a_empty_req_zero: assert property (
    (!lat_mode && !wr_cnt0 && (cfg[15:0] == 16'h0000)) |=> $stable(state.cnt0))
    else $error("counter 0 moved with no request type selected");

  a_bad_pattern_zero: assert property (
    (!lat_mode && !wr_cnt0 && !cfg[ocrf_pkg::BIT_ANY]
     && (cfg[ocrf_pkg::RSP_MSB:ocrf_pkg::SNP_LSB] == 7'h00))
    |=> $stable(state.cnt0))
    else $error("counter 0 moved with invalid response pattern");

  a_any_overrides: assert property (
    (norm_inc == (!lat_mode && i_rsp.valid && req_hit && cfg[ocrf_pkg::BIT_ANY]))
    || !cfg[ocrf_pkg::BIT_ANY])
    else $error("catch-all bit did not override response match");

  a_reserved_clear: assert property (
    ((state.cfg_a & ~ocrf_pkg::MASK_CFG_A) == '0) && ((state.cfg_b & ~ocrf_pkg::MASK_CFG_B) == '0))
    else $error("reserved filter bit found set");

  a_cfg_b_nolat: assert property (
    (i_wr && i_addr == ocrf_pkg::ADDR_CFG_B) |=> !state.cfg_b[ocrf_pkg::BIT_LAT_EN])
    else $error("config B kept a latency enable bit");

  a_lat_weighted: assert property (
    (lat_mode && !wr_cnt0) |=> (state.cnt0 == $past(state.cnt0) + $past(outst_ext)))
    else $error("counter 0 did not add outstanding requests");

  a_lat_occurs: assert property (
    (lat_issue && !wr_cnt1) |=> (state.cnt1 == $past(state.cnt1) + CNT_W'(1)))
    else $error("counter 1 missed a new request");

  a_read_answer: assert property (
    (i_rd && i_addr == ocrf_pkg::ADDR_CFG_A && !i_wr)
    |=> (o_rdata[15:0] == $past(state.cfg_a[15:0])) ##1 (o_rdata == 64'h0000_0000_0000_0000 || $past(i_rd)))
    else $error("config A read answer wrong or held too long");

  a_read_cfg_b: assert property (
    (i_rd && i_addr == ocrf_pkg::ADDR_CFG_B)
    |=> (o_rdata[ocrf_pkg::CFG_W-1:0] == $past(state.cfg_b)))
    else $error("config B read answer wrong");

  a_read_idle_zero: assert property (
    (!i_rd) |=> (o_rdata == 64'h0000_0000_0000_0000))
    else $error("read data stood without a read strobe");

  a_cfg_a_write: assert property (
    (i_wr && i_addr == ocrf_pkg::ADDR_CFG_A)
    |=> (state.cfg_a == ($past(i_wdata[ocrf_pkg::CFG_W-1:0]) & ocrf_pkg::MASK_CFG_A)))
    else $error("config A write did not land");

  a_no_evt_zero: assert property (
    (!is_evt && !wr_cnt0) |=> $stable(state.cnt0))
    else $error("counter 0 moved with the event not selected");

  a_other_sub_zero: assert property (
    (is_evt && !sel_a && !sel_b && !wr_cnt0) |=> $stable(state.cnt0))
    else $error("counter 0 moved under an unknown sub-code");

  a_supplier_needed: assert property (
    (!lat_mode && !wr_cnt0 && !cfg[ocrf_pkg::BIT_ANY] && !sup_any) |=> $stable(state.cnt0))
    else $error("counter 0 moved with no supplier match");

  a_snoop_needed: assert property (
    (!lat_mode && !wr_cnt0 && !cfg[ocrf_pkg::BIT_ANY] && !snp_any) |=> $stable(state.cnt0))
    else $error("counter 0 moved with no snoop match");

  a_match_counts: assert property (
    (!lat_mode && !wr_cnt0 && cfg_valid && i_rsp.valid && req_hit && sup_any && snp_any)
    |=> (state.cnt0 == $past(state.cnt0) + CNT_W'(1)))
    else $error("supplier and snoop match did not count");

  a_req_miss_zero: assert property (
    (!lat_mode && !wr_cnt0 && !req_hit) |=> $stable(state.cnt0))
    else $error("counter 0 moved for an unselected request type");

  a_cnt0_write: assert property (
    wr_cnt0 |=> (state.cnt0 == $past(i_wdata[CNT_W-1:0])))
    else $error("counter 0 write did not land");

  a_cnt1_write: assert property (
    wr_cnt1 |=> (state.cnt1 == $past(i_wdata[CNT_W-1:0])))
    else $error("counter 1 write did not land");

  a_cnt1_idle: assert property (
    (!lat_issue && !wr_cnt1) |=> $stable(state.cnt1))
    else $error("counter 1 moved with no new request");

  a_outst_up: assert property (
    (lat_issue && !lat_done && (state.outst != '1))
    |=> (state.outst == $past(state.outst) + OUT_W'(1)))
    else $error("outstanding count missed an issue");

  a_outst_down: assert property (
    (lat_done && !lat_issue) |=> (state.outst == $past(state.outst) - OUT_W'(1)))
    else $error("outstanding count missed a completion");

  a_outst_clear: assert property (
    (!lat_mode) |=> (state.outst == '0))
    else $error("outstanding count kept outside latency mode");

endmodule

`default_nettype wire

// ### dv/ocrf_core_model.sv
// Behavioural model of the core offcore request and response path
`timescale 1ns/100ps
`default_nettype none

module ocrf_core_model (
  // Clock
  input wire logic i_mclk,
  // Offcore path toward the filter
  output var ocrf_pkg::ocrf_req_s o_req,
  output var ocrf_pkg::ocrf_rsp_s o_rsp
);
  // Quiet at time zero
  initial begin
    o_req = '{valid: 1'b0, req_type: 16'h0000};
    o_rsp = '{valid: 1'b0, req_type: 16'h0000, info: 22'h000000};
  end

  // One-cycle request; idle fields turn inverted so stale data never passes for valid
  task automatic issue(input logic [15:0] t);
    @(posedge i_mclk) o_req <= '{valid: 1'b1, req_type: t};
    @(posedge i_mclk) o_req <= '{valid: 1'b0, req_type: ~t};
  endtask

  // One-cycle response after d idle cycles, so slow answers are possible
  task automatic answer(input logic [15:0] t, input logic [21:0] inf, input int d);
    repeat (d) @(posedge i_mclk);
    @(posedge i_mclk) o_rsp <= '{valid: 1'b1, req_type: t, info: inf};
    @(posedge i_mclk) o_rsp <= '{valid: 1'b0, req_type: ~t, info: ~inf};
  endtask
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking testbench for the offcore response event filter
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic i_mclk, i_rst_n, i_wr, i_rd; // Clock, reset, strobes
  logic [11:0] i_addr; // Register index
  logic [63:0] i_wdata, o_rdata, rv; // Bus data and last read
  ocrf_pkg::ocrf_evt_s i_evt; // Event selection
  ocrf_pkg::ocrf_req_s i_req; // From the core model
  ocrf_pkg::ocrf_rsp_s i_rsp; // From the core model
  logic [47:0] o_cnt0, o_cnt1; // Counter outputs
  logic o_lat_mode; // Latency mode flag
  int bad_count, total_checks; // Tallies

  ocrf_filter i_ocrf_filter (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt),
    .i_req(i_req), .i_rsp(i_rsp), .o_cnt0(o_cnt0), .o_cnt1(o_cnt1), .o_lat_mode(o_lat_mode));
  ocrf_core_model i_ocrf_core_model (.i_mclk(i_mclk), .o_req(i_req), .o_rsp(i_rsp));

  // Free-running 25 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Compare and tally
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Single-cycle register write
  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    @(posedge i_mclk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask

  // Single-cycle read; data taken in the following cycle only
  task automatic rd(input logic [11:0] a);
    @(posedge i_mclk) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask

  // Event selection change
  task automatic sel(input logic e, input logic [7:0] c, input logic [7:0] s);
    @(posedge i_mclk) i_evt <= '{enable: e, code: c, sub_code: s};
  endtask

  // One response, then the counter 0 step is judged
  task automatic rsp_chk(input logic [15:0] t, input logic [21:0] inf, input logic [47:0] n);
    logic [47:0] c;
    #1;
    c = o_cnt0;
    i_ocrf_core_model.answer(t, inf, 0);
    #1 check("cnt0 step", 64'(o_cnt0), 64'(c + n));
  endtask

  // Program config A, then answer with one response
  task automatic fcase(input logic [15:0] t, input logic [63:0] cfg, input logic [21:0] inf,
      input logic [47:0] n);
    wr(ocrf_pkg::ADDR_CFG_A, cfg);
    rsp_chk(t, inf, n);
  endtask

  // Reset values, masks, unmapped index, read data lifetime
  task automatic t_regs;
    rd(ocrf_pkg::ADDR_CFG_A); check("cfg_a rst", rv, 64'h0);
    rd(ocrf_pkg::ADDR_CFG_B); check("cfg_b rst", rv, 64'h0);
    rd(ocrf_pkg::ADDR_CNT_0); check("cnt0 rst", rv, 64'h0);
    wr(ocrf_pkg::ADDR_CFG_A, '1);
    rd(ocrf_pkg::ADDR_CFG_A); check("cfg_a mask", rv, 64'(ocrf_pkg::MASK_CFG_A));
    check("lat on", 64'(o_lat_mode), 64'h1);
    @(posedge i_mclk) #1 check("rdata drop", o_rdata, 64'h0);
    wr(ocrf_pkg::ADDR_CFG_B, '1);
    rd(ocrf_pkg::ADDR_CFG_B); check("cfg_b mask", rv, 64'(ocrf_pkg::MASK_CFG_B));
    sel(1'b1, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_B);
    #1 check("lat b", 64'(o_lat_mode), 64'h0);
    wr(12'h123, '1);
    rd(12'h123); check("unmapped", rv, 64'h0);
  endtask

  // Each request class alone, with catch-all response
  task automatic t_req_bits;
    sel(1'b1, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_A);
    for (int n = 0; n < 16; n++) begin
      fcase(16'h1 << n, 64'h1_0000 | (64'h1 << n), 22'h3FFFFF, 48'h1);
      rsp_chk(16'h1 << ((n + 1) % 16), 22'h3FFFFF, 48'h0);
    end
  endtask

  // Supplier and snoop qualification, validity of the pattern
  task automatic t_rsp;
    fcase(16'h1, 64'h1, 22'h3FFFFF, 48'h0);
    fcase(16'h1, 64'h1_0000, 22'h3FFFFF, 48'h0);
    fcase(16'h1, 64'h4_0001, 22'h008004, 48'h0);
    fcase(16'h1, 64'h8000_0001, 22'h008004, 48'h0);
    fcase(16'h1, 64'h8004_0001, 22'h008004, 48'h1);
    fcase(16'h1, 64'h8004_0001, 22'h000004, 48'h0);
    fcase(16'h1, 64'h6_0004_0001, 22'h040004, 48'h1);
    fcase(16'h1, 64'h10_0004_0001, 22'h100004, 48'h1);
    fcase(16'h1, 64'h2_0004_0001, 22'h100004, 48'h0);
    fcase(16'h1, 64'h20_0004_0001, 22'h200004, 48'h1);
    fcase(16'h2, 64'h1_0003, 22'h000000, 48'h1);
  endtask

  // Sub-code picks the filter register; other codes never count
  task automatic t_sub;
    wr(ocrf_pkg::ADDR_CFG_A, 64'h1_0001);
    wr(ocrf_pkg::ADDR_CFG_B, 64'h1_0002);
    sel(1'b1, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_B);
    rsp_chk(16'h2, 22'h000001, 48'h1);
    rsp_chk(16'h1, 22'h000001, 48'h0);
    sel(1'b1, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_A);
    rsp_chk(16'h1, 22'h000001, 48'h1);
    rsp_chk(16'h2, 22'h000001, 48'h0);
    sel(1'b1, 8'hB6, ocrf_pkg::SUB_CFG_A);
    rsp_chk(16'h1, 22'h000001, 48'h0);
  endtask

  // Latency mode: outstanding cycles and occurrences
  task automatic t_lat;
    logic [47:0] c0, c1;
    sel(1'b1, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_A);
    wr(ocrf_pkg::ADDR_CFG_A, 64'h40_0000_0001);
    #1 check("lat mode", 64'(o_lat_mode), 64'h1);
    c0 = o_cnt0;
    c1 = o_cnt1;
    i_ocrf_core_model.issue(16'h4);
    i_ocrf_core_model.issue(16'h1);
    i_ocrf_core_model.answer(16'h1, 22'h000000, 3);
    #1 check("lat sum", 64'(o_cnt0), 64'(c0 + 48'h5));
    check("lat occ", 64'(o_cnt1), 64'(c1 + 48'h1));
  endtask

  // Counter registers: write, truncation to width, read back
  task automatic t_cnt;
    sel(1'b0, ocrf_pkg::EVT_OFFCORE, ocrf_pkg::SUB_CFG_A);
    wr(ocrf_pkg::ADDR_CNT_0, 64'hABCD_1234_5678_9ABC);
    rd(ocrf_pkg::ADDR_CNT_0); check("cnt0 wr", rv, 64'h0000_1234_5678_9ABC);
    wr(ocrf_pkg::ADDR_CNT_1, 64'h0000_0000_0000_0055);
    rd(ocrf_pkg::ADDR_CNT_1); check("cnt1 wr", rv, 64'h0000_0000_0000_0055);
    check("cnt1 out", 64'(o_cnt1), 64'h0000_0000_0000_0055);
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    final_report();
  end

  // Main sequence
  initial begin
    bad_count = 0;
    total_checks = 0;
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 12'h000;
    i_wdata = 64'h0;
    i_evt = '{enable: 1'b1, code: ocrf_pkg::EVT_OFFCORE, sub_code: ocrf_pkg::SUB_CFG_A};
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_regs();
    t_req_bits();
    t_rsp();
    t_sub();
    t_lat();
    t_cnt();
    final_report();
  end
endmodule

`default_nettype wire
